// ---- design/sef_formatter.sv ----
// stream element formatter top: registers, stream control, output beats
`timescale 1ns/1ps

// Functional notes
// - promotion select: none, zero or sign extend
// - zero extension fills added bytes with zero
// - sign extension fills with copies of sign
// - promoted sub-element never exceeds 64 bits
// - lane width is sub-element times factor
// - complex element is two sub-elements wide
// - transpose select picks granule, seven reserved
// - tiny granules need matching decimation and promotion
// - granule at least the initial element size
// - decimation scales the minimum granule size
// - promoted granule fits one stream vector
// - transposed second count from 1 to 16
// - fetch first, then promote the fetched data
// - element type select gives size and kind
// - swapped complex halves exchange in lanes
// - inner dimension spans count times element bytes
// - lanes always delivered little-endian
// - nonzero reserved field gives bad first read
// - decimation select: none, two or four
// - formatted vector fits 64 native bytes
module sef_formatter
    import sef_pkg::*;
#(
    parameter int DATA_W = 64
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fetch_valid,
    input wire logic [DATA_W-1:0] fetch_data,
    output logic fetch_ready,
    output logic vec_valid,
    output logic [DATA_W-1:0] vec_data,
    output logic vec_bad,
    input wire logic vec_ready,
    output logic stream_active
);
    sef_cfg_if cfg ();

    logic [31:0] format;
    logic [31:0] dims;
    logic [31:0] rsvd;
    sef_state_e state;
    logic [DATA_W-1:0] word;
    logic [2:0] beat;
    logic [DATA_W-1:0] lanes;
    logic err_seen;
    logic [31:0] span;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic out_free;
    logic last_beat;
    logic [31:0] next_readdata;

    assign cfg.format = format;
    assign cfg.dims = dims;
    assign cfg.rsvd = rsvd;

    sef_check u_check (
        .cfg (cfg)
    );

    sef_promote u_promote (
        .cfg (cfg),
        .src (word),
        .beat (beat),
        .lanes (lanes)
    );

    // one-beat answer: request seen with waitrequest high, completes next edge
    assign bus_req = avs_read | avs_write;
    assign bus_wr = avs_write & ~avs_waitrequest;
    assign bus_rd = avs_read & ~avs_waitrequest;

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // byte-lane merge of a write into a register
    function automatic logic [31:0] sef_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : sef_merge

    // template registers; writes land only while the stream is closed
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            format <= SEF_FORMAT_RST;
            dims <= SEF_DIMS_RST;
            rsvd <= SEF_RSVD_RST;
        end else if (bus_wr && state == SEF_IDLE) begin
            case (avs_address)
                SEF_REG_FORMAT: begin
                    format <= sef_merge(format, avs_writedata, avs_byteenable);
                end
                SEF_REG_DIMS: begin
                    dims <= sef_merge(dims, avs_writedata, avs_byteenable);
                end
                SEF_REG_RSVD: begin
                    rsvd <= sef_merge(rsvd, avs_writedata, avs_byteenable);
                end
                default: begin
                end
            endcase
        end
    end

    // inner dimension span in bytes, count shifted by element size
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            span <= 32'h00000000;
        end else begin
            span <= 32'(dims[SEF_INNER_DIM_COUNT_LSB +: 16]) << cfg.elem_log;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        next_readdata = 32'h00000000;
        case (avs_address)
            SEF_REG_CTRL: next_readdata = {31'h0, stream_active};
            SEF_REG_FORMAT: next_readdata = format;
            SEF_REG_DIMS: next_readdata = dims;
            SEF_REG_RSVD: next_readdata = rsvd;
            SEF_REG_STATUS: begin
                next_readdata = {24'h0, 1'b0, cfg.elem_log, err_seen, cfg.err, state};
            end
            SEF_REG_SPAN: next_readdata = span;
            default: next_readdata = 32'h00000000;
        endcase
    end

    // read data captured as waitrequest falls
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // output register can take a new beat
    assign out_free = ~vec_valid | vec_ready;
    assign last_beat = (beat == 3'((3'h1 << cfg.prom_log) - 3'h1));

    // stream control: open checks template, bad template answers once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SEF_IDLE;
        end else if (bus_wr && avs_address == SEF_REG_CTRL && avs_writedata[SEF_CTRL_CLOSE]) begin
            state <= SEF_IDLE;
        end else begin
            case (state)
                SEF_IDLE: begin
                    if (bus_wr && avs_address == SEF_REG_CTRL && avs_writedata[SEF_CTRL_OPEN]) begin
                        state <= cfg.err ? SEF_BAD : SEF_ACTIVE;
                    end
                end
                SEF_ACTIVE: begin
                    if (fetch_valid && fetch_ready) begin
                        state <= SEF_EMIT;
                    end
                end
                SEF_EMIT: begin
                    if (out_free && last_beat) begin
                        state <= SEF_ACTIVE;
                    end
                end
                SEF_BAD: begin
                    if (out_free) begin
                        state <= SEF_IDLE;
                    end
                end
                default: state <= SEF_IDLE;
            endcase
        end
    end

    // fetch handshake: ready only while waiting for a word
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_ready <= 1'b0;
        end else if (state == SEF_ACTIVE && !(fetch_valid && fetch_ready)) begin
            fetch_ready <= 1'b1;
        end else begin
            fetch_ready <= 1'b0;
        end
    end

    // fetched word held whole while its beats are built
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            word <= '0;
        end else if (state == SEF_ACTIVE && fetch_valid && fetch_ready) begin
            word <= fetch_data;
        end
    end

    // beat counter within one fetched word
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            beat <= 3'h0;
        end else if (state != SEF_EMIT) begin
            beat <= 3'h0;
        end else if (out_free) begin
            beat <= beat + 3'h1;
        end
    end

    // output beats: promoted lanes, or a single bad-status beat
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_valid <= 1'b0;
            vec_data <= '0;
            vec_bad <= 1'b0;
        end else if (state == SEF_EMIT && out_free) begin
            vec_valid <= 1'b1;
            vec_data <= lanes;
            vec_bad <= 1'b0;
        end else if (state == SEF_BAD && out_free) begin
            vec_valid <= 1'b1;
            vec_data <= '0;
            vec_bad <= 1'b1;
        end else if (vec_ready) begin
            vec_valid <= 1'b0;
            vec_bad <= 1'b0;
        end
    end

    // sticky record that the last open hit a bad template
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_seen <= 1'b0;
        end else if (state == SEF_BAD) begin
            err_seen <= 1'b1;
        end else if (bus_wr && avs_address == SEF_REG_CTRL && avs_writedata[SEF_CTRL_OPEN]) begin
            err_seen <= 1'b0;
        end
    end

    // stream open flag for the core
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stream_active <= 1'b0;
        end else begin
            stream_active <= (state == SEF_ACTIVE) || (state == SEF_EMIT);
        end
    end
endmodule : sef_formatter

// ---- common/sef_pkg.sv ----
// shared constants and types of the stream element formatter
package sef_pkg;
    // register word indices; byte address is index times four
    localparam logic [3:0] SEF_REG_CTRL = 4'h0;
    localparam logic [3:0] SEF_REG_FORMAT = 4'h1;
    localparam logic [3:0] SEF_REG_DIMS = 4'h2;
    localparam logic [3:0] SEF_REG_RSVD = 4'h3;
    localparam logic [3:0] SEF_REG_STATUS = 4'h4;
    localparam logic [3:0] SEF_REG_SPAN = 4'h5;
    // control bits
    localparam int SEF_CTRL_OPEN = 0;
    localparam int SEF_CTRL_CLOSE = 1;
    // format word field positions
    localparam int SEF_ET_LSB = 0;
    localparam int SEF_PR_LSB = 4;
    localparam int SEF_TR_LSB = 8;
    localparam int SEF_DC_LSB = 12;
    localparam int SEF_DU_LSB = 16;
    localparam int SEF_VL_LSB = 20;
    localparam logic [31:0] SEF_FORMAT_RSVD_MASK = 32'hFF88C080;
    // dims word field positions
    localparam int SEF_INNER_DIM_COUNT_LSB = 0;
    localparam int SEF_SECOND_DIM_COUNT_LSB = 16;
    // values after reset
    localparam logic [31:0] SEF_FORMAT_RST = 32'h00000000;
    localparam logic [31:0] SEF_DIMS_RST = 32'h00010001;
    localparam logic [31:0] SEF_RSVD_RST = 32'h00000000;
    // codes
    localparam logic [2:0] SEF_PROMO_RSVD = 3'h4;
    localparam logic [3:0] SEF_TR_MAX = 4'h6;
    localparam logic [1:0] SEF_DECIMATION_SELECT_2 = 2'h1;
    localparam logic [1:0] SEF_DECIMATION_SELECT_4 = 2'h2;
    localparam logic [1:0] SEF_DECIMATION_SELECT_RSVD = 2'h3;
    localparam logic [2:0] SEF_DUP_RSVD = 3'h7;
    localparam logic [2:0] SEF_VL_RSVD = 3'h7;
    localparam logic [15:0] SEF_SECOND_DIM_COUNT_MAX = 16'h0010;
    localparam logic [4:0] SEF_NATIVE_LOG = 5'h06;
    localparam logic [2:0] SEF_LANE_MAX_LOG = 3'h3;
    // stream states, gray along idle-active-emit
    typedef enum logic [1:0] {
        SEF_IDLE = 2'b00,
        SEF_ACTIVE = 2'b01,
        SEF_EMIT = 2'b11,
        SEF_BAD = 2'b10
    } sef_state_e;
endpackage : sef_pkg

// ---- common/sef_cfg_if.sv ----
// template fields and their decoded form between formatter modules
`timescale 1ns/1ps
interface sef_cfg_if;
    logic [31:0] format;
    logic [31:0] dims;
    logic [31:0] rsvd;
    logic [1:0] sub_log;
    logic [2:0] elem_log;
    logic [1:0] prom_log;
    logic sign_ext;
    logic swap;
    logic err;
    modport top (output format, dims, rsvd, input sub_log, elem_log, prom_log, err);
    modport chk (input format, dims, rsvd,
                 output sub_log, elem_log, prom_log, sign_ext, swap, err);
    modport fmt (input sub_log, prom_log, sign_ext, swap);
endinterface : sef_cfg_if

// ---- design/sef_check.sv ----
// template decode and validity check
`timescale 1ns/1ps
module sef_check
    import sef_pkg::*;
(
    sef_cfg_if.chk cfg
);
    logic [3:0] et;
    logic [2:0] pr;
    logic [3:0] tr;
    logic [1:0] dc;
    logic [2:0] du;
    logic [2:0] vl;
    logic [15:0] second_dim_count;
    assign et = cfg.format[SEF_ET_LSB +: 4];
    assign pr = cfg.format[SEF_PR_LSB +: 3];
    assign tr = cfg.format[SEF_TR_LSB +: 4];
    assign dc = cfg.format[SEF_DC_LSB +: 2];
    assign du = cfg.format[SEF_DU_LSB +: 3];
    assign vl = cfg.format[SEF_VL_LSB +: 3];
    assign second_dim_count = cfg.dims[SEF_SECOND_DIM_COUNT_LSB +: 16];

    // decode sizes as base-two logs and flag bad templates
    always_comb begin
        logic [4:0] g_log;
        logic [4:0] e_log;
        logic [4:0] d_log;
        logic [4:0] p_log;
        logic bad;
        g_log = 5'(tr) - 5'h01;
        d_log = (dc == SEF_DECIMATION_SELECT_4) ? 5'h02 : ((dc == SEF_DECIMATION_SELECT_2) ? 5'h01 : 5'h00);
        e_log = 5'(et[1:0]) + 5'(et[3]);
        p_log = 5'(pr[1:0]);
        bad = (et[3:2] == 2'b01) || (pr == SEF_PROMO_RSVD) || (tr > SEF_TR_MAX);
        cfg.sub_log = et[1:0];
        cfg.elem_log = 3'(et[1:0]) + 3'(et[3]);
        cfg.swap = et[3] & et[2];
        cfg.prom_log = pr[1:0];
        cfg.sign_ext = pr[2];
        bad = bad || (dc == SEF_DECIMATION_SELECT_RSVD) || (du == SEF_DUP_RSVD) || (vl == SEF_VL_RSVD);
        bad = bad || (3'(et[1:0]) + 3'(pr[1:0]) > SEF_LANE_MAX_LOG);
        bad = bad || (5'(vl) + e_log + p_log + 5'(du) > SEF_NATIVE_LOG);
        bad = bad || (cfg.format & SEF_FORMAT_RSVD_MASK) != 32'h0 || cfg.rsvd != 32'h0;
        if (tr != 4'h0) begin
            bad = bad || (g_log < e_log);
            bad = bad || (tr == 4'h1 && !(dc == SEF_DECIMATION_SELECT_4 && pr[1:0] >= 2'h2));
            bad = bad || (tr == 4'h2 && !(dc == SEF_DECIMATION_SELECT_2 && pr[1:0] >= 2'h1));
            bad = bad || (tr >= 4'h3 && g_log < e_log + d_log);
            bad = bad || (g_log + p_log + d_log + 5'(du) > 5'(vl) + e_log + p_log);
            bad = bad || second_dim_count == 16'h0 || second_dim_count > SEF_SECOND_DIM_COUNT_MAX;
        end
        cfg.err = bad;
    end
endmodule : sef_check

// ---- design/sef_promote.sv ----
// lane builder: swap, promote and place one 64-bit output beat
`timescale 1ns/1ps
module sef_promote
    import sef_pkg::*;
(
    sef_cfg_if.fmt cfg,
    input wire logic [63:0] src,
    input wire logic [2:0] beat,
    output logic [63:0] lanes
);
    genvar b;
    // one output byte per pass, lanes in little-endian order
    generate
        for (b = 0; b < 8; b++) begin : g_byte
            always_comb begin
                logic [2:0] lane_log;
                logic [2:0] in_lane;
                logic [2:0] sub_idx;
                logic [2:0] top;
                lane_log = 3'(cfg.sub_log) + 3'(cfg.prom_log);
                in_lane = 3'(b) & ((3'h1 << lane_log) - 3'h1);
                sub_idx = 3'((beat << (3'h3 - lane_log)) + (3'(b) >> lane_log));
                sub_idx = sub_idx ^ {2'b00, cfg.swap};
                top = 3'((sub_idx << cfg.sub_log) + ((3'h1 << cfg.sub_log) - 3'h1));
                // widened compare so an eight-byte sub-element still copies
                if (4'(in_lane) < (4'h1 << cfg.sub_log)) begin
                    lanes[b*8 +: 8] = src[(3'((sub_idx << cfg.sub_log) + in_lane))*8 +: 8];
                end else if (cfg.sign_ext) begin
                    lanes[b*8 +: 8] = {8{src[top*8 + 7]}};
                end else begin
                    lanes[b*8 +: 8] = 8'h00;
                end
            end
        end
    endgenerate
endmodule : sef_promote

// ---- test/sef_core_model.sv ----
// core model: takes output beats, steadily or with stalls
`timescale 1ns/1ps
module sef_core_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic slow,
    output logic vec_ready
);
    logic phase;
    // stall toggle, used in slow mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end
    // ready every cycle, or every other cycle when slow
    assign vec_ready = reset_n && (!slow || phase);
endmodule : sef_core_model

// ---- test/sef_formatter_chk.sv ----
// port checks of the stream element formatter
`timescale 1ns/1ps
module sef_formatter_chk
    import sef_pkg::*;
#(
    parameter int DATA_W = 64
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic fetch_valid,
    input wire logic fetch_ready,
    input wire logic vec_valid,
    input wire logic [DATA_W-1:0] vec_data,
    input wire logic vec_bad,
    input wire logic vec_ready,
    input wire logic stream_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // fetch word taken, then its first beat
    sequence s_take;
        fetch_valid && fetch_ready;
    endsequence
    sequence s_first_beat;
        ##2 vec_valid;
    endsequence
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > SEF_REG_SPAN |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    a_beat_hold: assert property (vec_valid && !vec_ready
        |=> vec_valid && $stable(vec_data) && $stable(vec_bad))
        else $error("beat changed while stalled");
    a_bad_empty: assert property (vec_valid && vec_bad |-> vec_data == '0)
        else $error("bad beat carries data");
    a_fetch_gap: assert property (s_take |=> !fetch_ready)
        else $error("fetch ready right after a take");
    a_fetch_open: assert property (fetch_ready |-> stream_active)
        else $error("fetch ready while closed");
    a_first_beat: assert property (s_take |-> s_first_beat)
        else $error("first beat not two cycles after fetch");
    a_bad_close: assert property (vec_valid && vec_bad && vec_ready
        |=> !vec_valid && !stream_active) else $error("more than one bad beat");
endmodule : sef_formatter_chk
bind sef_formatter sef_formatter_chk #(.DATA_W(DATA_W)) u_sef_formatter_chk (
    .sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .fetch_valid, .fetch_ready, .vec_valid, .vec_data,
    .vec_bad, .vec_ready, .stream_active);

// ---- test/sef_formatter_tb_top.sv ----
// self-checking bench of the stream element formatter
`timescale 1ns/1ps
module sef_formatter_tb_top
    import sef_pkg::*;
;
    logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, slow;
    logic fetch_valid, fetch_ready, vec_valid, vec_bad, vec_ready, stream_active;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [63:0] fetch_data, vec_data, w;
    logic [64:0] bq[$];
    int bad_count = 0;
    int checks_done = 0;
    // template table: error flag above format word
    logic [32:0] tab[17] = '{33'h0_00000000, 33'h1_00000004, 33'h1_00000040,
        33'h1_00000013, 33'h0_00000012, 33'h1_00000700, 33'h1_00003000,
        33'h1_00000080, 33'h1_00600003, 33'h0_00600000, 33'h1_00000100,
        33'h0_00202120, 33'h1_00002120, 33'h1_00001302, 33'h0_00201301,
        33'h1_00000303, 33'h0_00101211};
    // data cases: format, sub log, promote log, sign, swap
    logic [31:0] dfmt[6] = '{32'h30, 32'h70, 32'h51, 32'h1C, 32'h0D, 32'h03};
    int dsl[6] = '{0, 0, 1, 0, 1, 3};
    int dpl[6] = '{3, 3, 1, 1, 0, 0};
    int dsg[6] = '{0, 1, 1, 0, 0, 0};
    int dsw[6] = '{0, 0, 0, 1, 1, 0};
    sef_formatter u_sef_formatter (.sys_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .fetch_valid, .fetch_data, .fetch_ready, .vec_valid, .vec_data, .vec_bad,
        .vec_ready, .stream_active);
    sef_core_model u_sef_core_model (.sys_clk, .reset_n, .slow, .vec_ready);
    always #20 sys_clk = ~sys_clk;
    // capture every beat taken by the core
    always @(posedge sys_clk) begin
        if (vec_valid === 1'b1 && vec_ready === 1'b1) begin
            bq.push_back({vec_bad, vec_data});
        end
    end
    task automatic chk(input string nm, input logic [64:0] e, input logic [64:0] g);
        checks_done++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // hold until waitrequest is seen low; only the watchdog ends a hang
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d;
    endtask : bus
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd_chk
    task automatic feed(input logic [63:0] d);
        int n;
        @(posedge sys_clk);
        fetch_valid <= 1'b1;
        fetch_data <= d;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (fetch_ready === 1'b1) break;
        end
        if (n == 40) bad_count++;
        fetch_valid <= 1'b0;
        fetch_data <= ~d;
    endtask : feed
    task automatic wait_beats(input int k);
        int n;
        for (n = 0; n < 200 && bq.size() < k; n++) @(posedge sys_clk);
        if (n == 200) bad_count++;
    endtask : wait_beats
    // expected beat k of a word, lanes little-endian
    function automatic logic [63:0] exp_beat(logic [63:0] d, int sl, int pl, int sg,
        int sw, int k);
        logic [63:0] r;
        int b, i, o, lw;
        r = '0;
        lw = sl + pl;
        for (b = 0; b < 8; b++) begin
            i = (k << (3 - lw)) + (b >> lw);
            if (sw != 0) i = i ^ 1;
            o = b & ((1 << lw) - 1);
            if (o < (1 << sl)) r[8*b +: 8] = d[8*((i << sl) + o) +: 8];
            else r[8*b +: 8] = (sg != 0 && d[8*((i + 1) << sl) - 1]) ? 8'hFF : 8'h00;
        end
        return r;
    endfunction : exp_beat
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    // watchdog against a hang
    initial begin
        #(40 * 20000);
        bad_count++;
        test_done();
    end
    initial begin
        {sys_clk, reset_n, avs_read, avs_write, fetch_valid, slow} = '0;
        {avs_address, avs_writedata, fetch_data} = '0;
        avs_byteenable = 4'hF;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd_chk("format", SEF_REG_FORMAT, SEF_FORMAT_RST);
        rd_chk("dims", SEF_REG_DIMS, SEF_DIMS_RST);
        rd_chk("rsvd", SEF_REG_RSVD, SEF_RSVD_RST);
        rd_chk("status", SEF_REG_STATUS, 32'h0);
        rd_chk("span", SEF_REG_SPAN, 32'h1);
        rd_chk("unmapped", 4'hF, 32'h0);
        $display("test reset done");
        // template error flag per format, one entry with reserved format bit 7 set
        for (int t = 0; t < 17; t++) begin
            bus(1'b1, SEF_REG_FORMAT, tab[t][31:0]);
            bus(1'b0, SEF_REG_STATUS, 32'h0);
            chk("tmpl_err", tab[t][32], q[2]);
        end
        bus(1'b1, SEF_REG_FORMAT, 32'h302);
        for (int t = 0; t < 3; t++) begin
            bus(1'b1, SEF_REG_DIMS, {16'((t == 0) ? 0 : 15 + t), 16'h1});
            bus(1'b0, SEF_REG_STATUS, 32'h0);
            chk("second_cnt", t != 1, q[2]);
        end
        bus(1'b1, SEF_REG_FORMAT, 32'h0);
        bus(1'b1, SEF_REG_RSVD, 32'h100);
        rd_chk("rsvd_err", SEF_REG_STATUS, 32'h4);
        bus(1'b1, SEF_REG_RSVD, 32'h0);
        bus(1'b1, SEF_REG_FORMAT, 32'h0B);
        bus(1'b1, SEF_REG_DIMS, 32'h00010005);
        rd_chk("span", SEF_REG_SPAN, 32'h50);
        rd_chk("status", SEF_REG_STATUS, 32'h40);
        $display("test template done");
        // bad template opened: one empty bad beat, then closed
        bus(1'b1, SEF_REG_FORMAT, 32'h40);
        bus(1'b1, SEF_REG_CTRL, 32'h1);
        wait_beats(1);
        chk("bad_beat", {1'b1, 64'h0}, bq.pop_front());
        rd_chk("ctrl", SEF_REG_CTRL, 32'h0);
        rd_chk("status", SEF_REG_STATUS, 32'hC);
        $display("test bad open done");
        // good streams, two words each, stalls on odd cases
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, SEF_REG_FORMAT, dfmt[c]);
            bus(1'b1, SEF_REG_CTRL, 32'h1);
            slow <= c[0];
            if (c == 0) begin
                bus(1'b1, SEF_REG_FORMAT, 32'h70);
                rd_chk("locked", SEF_REG_FORMAT, 32'h30);
                rd_chk("status", SEF_REG_STATUS, 32'h1);
            end
            for (int h = 0; h < 2; h++) begin
                w = h ? 64'h0E1D2C3B4A596877 : 64'hF1E2D3C4B5A69788;
                feed(w);
                wait_beats(1 << dpl[c]);
                for (int k = 0; k < (1 << dpl[c]); k++) begin
                    chk("beat", {1'b0, exp_beat(w, dsl[c], dpl[c], dsg[c], dsw[c], k)},
                        bq.pop_front());
                end
            end
            bus(1'b1, SEF_REG_CTRL, 32'h2);
            rd_chk("closed", SEF_REG_CTRL, 32'h0);
        end
        bus(1'b1, SEF_REG_CTRL, 32'h3);
        rd_chk("close_wins", SEF_REG_CTRL, 32'h0);
        chk("extra_beats", 0, bq.size());
        $display("test data done");
        test_done();
    end
endmodule : sef_formatter_tb_top
